/* File: hw/spm_consts.svh */
// Offsets, field positions, reset values and widths of the stochastic performance monitor.
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH
`define SPM_OFF_CONTROL   12'h044
`define SPM_OFF_ESTIMATE0 12'h048
`define SPM_OFF_ESTIMATE1 12'h04c
`define SPM_OFF_SAMPLES0  12'h050
`define SPM_OFF_SAMPLES1  12'h054
`define SPM_OFF_RESET     12'h058
`define SPM_SEL0_LSB      0
`define SPM_SEL1_LSB      4
`define SPM_SEL_W         3
`define SPM_CONTROL_MASK  32'h0000_0077
`define SPM_LFSR_W        31
`define SPM_LFSR_TAP      3
`define SPM_LFSR_SEED     31'h0000_0001
`define SPM_DEF_WIDTH     8
`define SPM_SAMPLE_W      16
`define SPM_SRC_N         5
`define SPM_GROUP_W       4
`endif

/* File: hw/spm_pkg.sv */
// Types shared by the stochastic performance monitor.
package spm_pkg;
  typedef enum logic [2:0] {
    SRC_DISABLED, SRC_PAGE_BANK_MISS, SRC_WRBUF_HIT, SRC_READ_MERGE_HIT,
    SRC_WRBUF_FULL, SRC_RDBUF_HIT, SRC_RESERVED6, SRC_RESERVED7
  } source_select_e;
  typedef struct packed {
    logic page_bank_miss;
    logic wrbuf_hit;
    logic read_merge_hit;
    logic wrbuf_full;
    logic rdbuf_hit;
  } event_bits_s;
  typedef struct packed {
    logic        valid;
    event_bits_s bits;
  } event_sample_s;
endpackage

/* File: hw/stochastic_perf_monitor.sv */
// Two stochastic integrators with source multiplexers, a shared random source and an APB port.
`timescale 1ns/100ps
`default_nettype none
`include "spm_consts.svh"

module stochastic_perf_monitor
  import spm_pkg::*;
#(
  parameter int WIDTH    = `SPM_DEF_WIDTH,
  parameter int SAMPLE_W = `SPM_SAMPLE_W,
  parameter int GROUP_W  = `SPM_GROUP_W
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 dap_req,
  input  wire logic                 dap_write,
  input  wire logic [11:0]          dap_addr,
  input  wire logic [31:0]          dap_wdata,
  output logic      [31:0]          dap_rdata,
  output logic                      dap_ack,
  input  wire logic                 prog_reset,
  input  wire event_sample_s        events0,
  input  wire event_sample_s        events1,
  input  wire logic                 group_load0,
  input  wire logic                 group_load1,
  input  wire logic [GROUP_W-1:0]   group_value0,
  input  wire logic [GROUP_W-1:0]   group_value1,
  input  wire logic                 group_mode0,
  input  wire logic                 group_mode1
);

  localparam logic [WIDTH-1:0] MID_SCALE = {1'b1, {(WIDTH-1){1'b0}}};
  localparam logic [WIDTH-1:0] ALL_ONES  = '1;
  localparam logic [WIDTH-1:0] ALL_ZERO  = '0;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Register writes: APB and the debug access port share one decoder. The debug port
  // wins a cycle in which both fire, and the APB access then simply waits a cycle.
  // The debug port holds dap_req until it sees dap_ack; a request still high after the
  // acknowledge cycle is taken as a fresh access, so the port must drop it promptly.

  logic [`SPM_SEL_W-1:0]  sel [2];
  logic [WIDTH-1:0]       estimate [2];
  logic [SAMPLE_W-1:0]    samples [2];
  logic                   apb_fire;
  logic                   acc_fire;
  logic                   acc_write;
  logic [11:0]            acc_addr;
  logic [31:0]            acc_wdata;
  logic [31:0]            acc_rdata;
  logic [31:0]            apb_rdata;
  logic                   apb_mapped;
  logic                   ctl_write;
  logic                   ctl_lane_ok;
  logic                   dap_busy;

  assign dap_busy    = dap_req && !dap_ack;
  assign apb_fire    = psel && penable && !dap_busy;
  assign acc_fire    = dap_busy || apb_fire;
  assign acc_write   = dap_busy ? dap_write : pwrite;
  assign acc_addr    = dap_busy ? dap_addr  : paddr;
  assign acc_wdata   = dap_busy ? dap_wdata : pwdata;
  assign ctl_lane_ok = dap_busy || pstrb[0];
  assign ctl_write   = acc_fire && acc_write && ctl_lane_ok
                       && acc_addr == `SPM_OFF_CONTROL;
  assign pready      = psel && penable && !dap_busy;

  // Debug reads go through the shared decoder; an unmapped address reads zero.
  always_comb begin
    acc_rdata = 32'h0000_0000;
    unique case (acc_addr)
      `SPM_OFF_CONTROL:   acc_rdata = {25'h0, sel[1], 1'b0, sel[0]};
      `SPM_OFF_ESTIMATE0: acc_rdata = 32'(estimate[0]);
      `SPM_OFF_ESTIMATE1: acc_rdata = 32'(estimate[1]);
      `SPM_OFF_SAMPLES0:  acc_rdata = 32'(samples[0]);
      `SPM_OFF_SAMPLES1:  acc_rdata = 32'(samples[1]);
      `SPM_OFF_RESET:     acc_rdata = 32'h0000_0000;
      default:            acc_rdata = 32'h0000_0000;
    endcase
  end

  // APB reads decode paddr on their own and load prdata through the setup and wait cycles,
  // so the word is already registered and stable at the edge where pready is high. The
  // value is a snapshot taken in the last setup or wait cycle, before pready rises.
  always_comb begin
    apb_rdata  = 32'h0000_0000;
    apb_mapped = 1'b1;
    unique case (paddr)
      `SPM_OFF_CONTROL:   apb_rdata = {25'h0, sel[1], 1'b0, sel[0]};
      `SPM_OFF_ESTIMATE0: apb_rdata = 32'(estimate[0]);
      `SPM_OFF_ESTIMATE1: apb_rdata = 32'(estimate[1]);
      `SPM_OFF_SAMPLES0:  apb_rdata = 32'(samples[0]);
      `SPM_OFF_SAMPLES1:  apb_rdata = 32'(samples[1]);
      `SPM_OFF_RESET:     apb_rdata = 32'h0000_0000;
      default:            apb_mapped = 1'b0;
    endcase
  end

  assign pslverr = pready && !apb_mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !pwrite && !pready) begin
      prdata <= apb_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dap_rdata <= 32'h0000_0000;
      dap_ack   <= 1'b0;
    end else begin
      dap_ack <= dap_busy;
      if (dap_busy && !dap_write) begin
        dap_rdata <= acc_rdata;
      end
    end
  end

  // Programmable reset comes from the pin or from a write of bit 0 to the reset register.
  logic soft_reset;
  logic prog_reset_meta;
  logic prog_reset_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_reset_meta <= 1'b0;
      prog_reset_sync <= 1'b0;
    end else begin
      prog_reset_meta <= prog_reset;
      prog_reset_sync <= prog_reset_meta;
    end
  end

  assign soft_reset = prog_reset_sync
                      || (acc_fire && acc_write && acc_addr == `SPM_OFF_RESET && acc_wdata[0]);

  // The select survives a programmable reset; only power-on reset clears it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel[0] <= '0;
      sel[1] <= '0;
    end else if (ctl_write) begin
      sel[0] <= acc_wdata[`SPM_SEL0_LSB +: `SPM_SEL_W];
      sel[1] <= acc_wdata[`SPM_SEL1_LSB +: `SPM_SEL_W];
    end
  end

  // After a programmable reset the integrators stay off until the select is rewritten.
  logic [1:0] armed;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 2'b00;
    end else if (ctl_write) begin
      armed <= 2'b11;
    end else if (soft_reset) begin
      armed <= 2'b00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Shared random source. It runs every cycle, so numbers seen by the two integrators
  // are the same, which costs a little independence but saves a second register.

  logic [`SPM_LFSR_W-1:0] lfsr;
  logic [WIDTH-1:0]       random;

  // The seed must be non-zero: an all-zero register would never leave that state.

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr <= `SPM_LFSR_SEED;
    end else begin
      lfsr <= {lfsr[`SPM_LFSR_W-2:0],
               lfsr[`SPM_LFSR_TAP-1] ^ lfsr[`SPM_LFSR_W-1]};
    end
  end

  assign random = {~lfsr[`SPM_LFSR_W-1], lfsr[`SPM_LFSR_W-2 -: (WIDTH-1)]};

  //////////////////////////////////////////////////////////////////////////////////////////
  // Integrators.

  event_sample_s        ev_meta [2];
  event_sample_s        ev_sync [2];
  logic                 gl_meta [2];
  logic                 gl_sync [2];
  logic [GROUP_W-1:0]   gv_meta [2];
  logic [GROUP_W-1:0]   gv_sync [2];
  logic                 gm_meta [2];
  logic                 gm_sync [2];

  // Each outside input passes two flops. The valid bit and the event bits travel in one
  // word, so they stay aligned as long as the source changes them in the same clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) begin
        ev_meta[i] <= '0;
        ev_sync[i] <= '0;
        gl_meta[i] <= 1'b0;
        gl_sync[i] <= 1'b0;
        gv_meta[i] <= '0;
        gv_sync[i] <= '0;
        gm_meta[i] <= 1'b0;
        gm_sync[i] <= 1'b0;
      end
    end else begin
      ev_meta[0] <= events0;
      ev_meta[1] <= events1;
      gl_meta[0] <= group_load0;
      gl_meta[1] <= group_load1;
      gv_meta[0] <= group_value0;
      gv_meta[1] <= group_value1;
      gm_meta[0] <= group_mode0;
      gm_meta[1] <= group_mode1;
      for (int i = 0; i < 2; i++) begin
        ev_sync[i] <= ev_meta[i];
        gl_sync[i] <= gl_meta[i];
        gv_sync[i] <= gv_meta[i];
        gm_sync[i] <= gm_meta[i];
      end
    end
  end

  for (genvar m = 0; m < 2; m++) begin : g_mon
    logic               mux_bit;
    logic               mux_valid;
    logic               in_bit;
    logic               in_valid;
    logic               cmp_bit;
    logic               differ;
    logic               enabled;
    logic [GROUP_W-1:0] group;
    logic [$clog2(GROUP_W+1)-1:0] group_left;
    logic               wr_sel;

    assign enabled = armed[m] && sel[m] != SRC_DISABLED && sel[m] != SRC_RESERVED6
                     && sel[m] != SRC_RESERVED7;
    assign wr_sel  = ctl_write;

    always_comb begin
      mux_bit = 1'b0;
      unique case (source_select_e'(sel[m]))
        SRC_PAGE_BANK_MISS: mux_bit = ev_sync[m].bits.page_bank_miss;
        SRC_WRBUF_HIT:      mux_bit = ev_sync[m].bits.wrbuf_hit;
        SRC_READ_MERGE_HIT: mux_bit = ev_sync[m].bits.read_merge_hit;
        SRC_WRBUF_FULL:     mux_bit = ev_sync[m].bits.wrbuf_full;
        SRC_RDBUF_HIT:      mux_bit = ev_sync[m].bits.rdbuf_hit;
        SRC_DISABLED, SRC_RESERVED6, SRC_RESERVED7: mux_bit = 1'b0;
      endcase
    end
    assign mux_valid = ev_sync[m].valid;

    // Pulse group front end: a value v loads v ones which shift out one per cycle.
    // A load that comes while a group is still shifting is ignored; the source paces them.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        group      <= '0;
        group_left <= '0;
      end else if (soft_reset || wr_sel) begin
        group_left <= '0;
      end else if (gm_sync[m] && gl_sync[m] && group_left == '0) begin
        for (int b = 0; b < GROUP_W; b++) begin
          group[b] <= (b < int'(gv_sync[m]));
        end
        group_left <= ($clog2(GROUP_W+1))'(GROUP_W);
      end else if (group_left != '0) begin
        group      <= group >> 1;
        group_left <= group_left - 1'b1;
      end
    end

    assign in_bit   = gm_sync[m] ? group[0] : mux_bit;
    assign in_valid = gm_sync[m] ? group_left != '0 : mux_valid;
    assign cmp_bit  = estimate[m] > random;
    assign differ   = in_bit ^ cmp_bit;

    // A step that would pass either end is dropped, so the counter never wraps.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        estimate[m] <= MID_SCALE;
      end else if (soft_reset) begin
        estimate[m] <= MID_SCALE;
      end else if (enabled && in_valid && differ) begin
        if (in_bit && estimate[m] != ALL_ONES) begin
          estimate[m] <= estimate[m] + 1'b1;
        end else if (!in_bit && estimate[m] != ALL_ZERO) begin
          estimate[m] <= estimate[m] - 1'b1;
        end
      end
    end

    // The sample count saturates rather than wrapping, so a long run never looks fresh.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        samples[m] <= '0;
      end else if (soft_reset || wr_sel) begin
        samples[m] <= '0;
      end else if (enabled && in_valid && samples[m] != '1) begin
        samples[m] <= samples[m] + 1'b1;
      end
    end
  end

endmodule // stochastic_perf_monitor

`default_nettype wire

/* File: tb/spm_checker.sv */
// Port-level assertions of the stochastic performance monitor.
`timescale 1ns/100ps
`default_nettype none
`include "spm_consts.svh"
module spm_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        dap_req,
  input wire logic        dap_ack
);
  logic acc;
  logic hit;
  logic rd_reset;
  logic rd_est;
  logic rd_load;
  assign acc = psel && penable && pready;
  assign hit = paddr inside {`SPM_OFF_CONTROL, `SPM_OFF_ESTIMATE0, `SPM_OFF_ESTIMATE1,
                             `SPM_OFF_SAMPLES0, `SPM_OFF_SAMPLES1, `SPM_OFF_RESET};
  assign rd_reset = acc && !pwrite && paddr == `SPM_OFF_RESET;
  assign rd_est   = acc && !pwrite && paddr inside {`SPM_OFF_ESTIMATE0, `SPM_OFF_ESTIMATE1};
  // Read data is loaded during setup and wait cycles and must stand while pready is high.
  assign rd_load  = psel && !pwrite && !pready;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error response without ready");
  AST_IDLE_QUIET: assert property (!(psel && penable) |-> !pready && !pslverr)
    else $error("response outside an access phase");
  AST_READY_SOON: assert property (psel && penable |-> ##[0:2] pready)
    else $error("access phase not answered in time");
  AST_UNMAPPED_ERR: assert property (acc && !hit |-> pslverr)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (acc && hit |-> !pslverr)
    else $error("mapped access refused");
  AST_RESET_REG_ZERO: assert property (rd_reset |-> prdata == 32'h0)
    else $error("reset register read not zero");
  AST_EST_BYTE: assert property (rd_est |-> prdata[31:8] == 24'h0)
    else $error("estimate wider than eight bits");
  AST_PRDATA_HELD: assert property (!$stable(prdata) |-> $past(rd_load))
    else $error("read data changed without a read");
  AST_ACK_AFTER_REQ: assert property (dap_ack |-> $past(dap_req))
    else $error("debug acknowledge without request");
endmodule // spm_checker
bind stochastic_perf_monitor spm_checker i_spm_checker (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .dap_req(dap_req), .dap_ack(dap_ack));
`default_nettype wire

/* File: tb/spm_event_source.sv */
// Behavioural model of the controller event lines that feed the monitor.
`timescale 1ns/100ps
`default_nettype none
module spm_event_source
  import spm_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [4:0] hot,
  output var event_sample_s events
);
  logic [2:0] phase;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
    end
  end
  // Samples come at an uneven pace; idle cycles carry inverted bits so stale data cannot pass.
  assign events.valid = phase[0] ^ phase[2];
  assign events.bits  = events.valid ? hot : ~hot;
endmodule // spm_event_source
`default_nettype wire

/* File: tb/stochastic_perf_monitor_tb.sv */
// Self-checking testbench of the stochastic performance monitor.
`timescale 1ns/100ps
`default_nettype none
`include "spm_consts.svh"
module stochastic_perf_monitor_tb;
  import spm_pkg::*;
  logic          pclk, presetn, psel, penable, pwrite, dap_req, dap_write, prog_reset;
  logic          pready, pslverr, dap_ack, err, group_load0, group_mode0;
  logic [11:0]   paddr, dap_addr;
  logic [31:0]   pwdata, dap_wdata, prdata, dap_rdata, rd;
  logic [3:0]    group_value0;
  logic [4:0]    hot;
  event_sample_s events;
  int            n_fail, total_checks;
  stochastic_perf_monitor i_stochastic_perf_monitor (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dap_req(dap_req),
    .dap_write(dap_write), .dap_addr(dap_addr), .dap_wdata(dap_wdata),
    .dap_rdata(dap_rdata), .dap_ack(dap_ack), .prog_reset(prog_reset), .events0(events),
    .events1(events), .group_load0(group_load0), .group_load1(1'b0),
    .group_value0(group_value0), .group_value1(4'h0), .group_mode0(group_mode0),
    .group_mode1(1'b0));
  spm_event_source i_spm_event_source (.pclk(pclk), .presetn(presetn), .hot(hot),
    .events(events));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // If pready never rises, only the watchdog ends this wait; the answer is taken at the edge that sees pready.
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic dap(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    dap_req <= 1'b1;
    dap_write <= w;
    dap_addr <= a;
    dap_wdata <= d;
    do @(posedge pclk); while (dap_ack !== 1'b1);
    rd = dap_rdata;
    dap_req <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    rd_chk(`SPM_OFF_CONTROL, 32'h0);
    rd_chk(`SPM_OFF_ESTIMATE0, 32'h80);
    rd_chk(`SPM_OFF_ESTIMATE1, 32'h80);
    rd_chk(`SPM_OFF_SAMPLES0, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
  endtask
  task automatic t_frozen;
    hot <= 5'h1f;
    repeat (300) @(posedge pclk);
    rd_chk(`SPM_OFF_ESTIMATE0, 32'h80);
    apb(1'b1, `SPM_OFF_CONTROL, 32'h6);
    repeat (300) @(posedge pclk);
    rd_chk(`SPM_OFF_ESTIMATE0, 32'h80);
    rd_chk(`SPM_OFF_SAMPLES0, 32'h0);
  endtask
  task automatic t_sources;
    logic [31:0] ctrl;
    for (int c = 1; c <= 5; c++) begin
      @(posedge pclk);
      prog_reset <= 1'b1;
      repeat (4) @(posedge pclk);
      prog_reset <= 1'b0;
      repeat (4) @(posedge pclk);
      rd_chk(`SPM_OFF_ESTIMATE0, 32'h80);
      if (c > 1) rd_chk(`SPM_OFF_CONTROL, ctrl);
      ctrl = {25'h0, 3'(c % 5 + 1), 1'b0, 3'(c)};
      hot <= 5'h10 >> (c - 1);
      apb(1'b1, `SPM_OFF_CONTROL, ctrl);
      // The source offers four valid words in every eight cycles, so this lets 500 samples pass.
      repeat (1000) @(posedge pclk);
      apb(1'b0, `SPM_OFF_SAMPLES0, 32'h0);
      chk(32'(rd >= 32'h0000_01f4), 32'h1);
      apb(1'b0, `SPM_OFF_ESTIMATE0, 32'h0);
      chk(32'(rd > 32'hc0), 32'h1);
      apb(1'b0, `SPM_OFF_ESTIMATE1, 32'h0);
      chk(32'(rd < 32'h40), 32'h1);
    end
  endtask
  task automatic t_dap;
    logic [31:0] held;
    dap(1'b0, `SPM_OFF_CONTROL, 32'h0);
    chk(rd, 32'h15);
    dap(1'b1, `SPM_OFF_CONTROL, 32'h5);
    apb(1'b0, `SPM_OFF_SAMPLES0, 32'h0);
    chk(32'(rd < 32'h8), 32'h1);
    rd_chk(`SPM_OFF_CONTROL, 32'h5);
    // Monitor 1 is now switched off, so its estimate must stay where it stopped.
    apb(1'b0, `SPM_OFF_ESTIMATE1, 32'h0);
    held = rd;
    repeat (200) @(posedge pclk);
    rd_chk(`SPM_OFF_ESTIMATE1, held);
  endtask
  task automatic t_group;
    apb(1'b1, `SPM_OFF_RESET, 32'h1);
    rd_chk(`SPM_OFF_ESTIMATE0, 32'h80);
    rd_chk(`SPM_OFF_RESET, 32'h0);
    group_mode0 <= 1'b1;
    group_value0 <= 4'h3;
    hot <= 5'h10;
    apb(1'b1, `SPM_OFF_CONTROL, 32'h1);
    repeat (120) begin
      group_load0 <= 1'b1;
      @(posedge pclk);
      group_load0 <= 1'b0;
      repeat (5) @(posedge pclk);
    end
    apb(1'b0, `SPM_OFF_ESTIMATE0, 32'h0);
    // Three ones in each group of four settle near three quarters of full scale.
    chk(32'(rd > 32'ha0 && rd < 32'he0), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("Checks %0d, errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, dap_req, dap_write, prog_reset} = 7'h0;
    {group_load0, group_mode0, group_value0, hot} = 11'h0;
    {paddr, dap_addr, pwdata, dap_wdata} = 88'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values;
    t_frozen;
    t_sources;
    t_dap;
    t_group;
    close_out;
  end
  initial begin
    #400000;
    n_fail++;
    $display("Error %0t watchdog expired", $time);
    close_out;
  end
endmodule // stochastic_perf_monitor_tb
`default_nettype wire
